// ==== host_bus_model.sv ====
// Host processor model on the register port
`timescale 1ns/1ns
module host_bus_model (
    // Clock and status
    input wire logic ref_clk_in,
    input wire logic ready_in,
    // Register port
    output logic [7:0] addr_out,
    output logic [31:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    input wire logic [31:0] rdata_in
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 32'h0000_0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // Host waits for ready before touching other places
    task automatic wait_ready();
        int k = 0;
        while (ready_in !== 1'b1 && k < 100) begin
            @(posedge ref_clk_in);
            k++;
        end
    endtask
    // Stale data never left on the bus after a write
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge ref_clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    endtask
    task automatic read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge ref_clk_in);
        rd_out <= 1'b0;
        #1 d = rdata_in;
    endtask
endmodule

// ==== pm_pkg.sv ====
// Package: register map, field positions and timing for the power management block
package pm_pkg;
    localparam logic [7:0] ADDR_BYTE_TEST = 8'h64;
    localparam logic [7:0] ADDR_HARDWARE_CONFIG_REG = 8'h74;
    localparam logic [7:0] ADDR_PM_CTRL = 8'h84;
    localparam int MODE_HI = 13;
    localparam int MODE_LO = 12;
    localparam int XRST_BIT = 10;
    localparam int LANW_BIT = 9;
    localparam int ENDET_BIT = 8;
    localparam int BUFT_BIT = 6;
    localparam int CAUSE_HI = 5;
    localparam int CAUSE_LO = 4;
    localparam int PULSE_BIT = 3;
    localparam int POL_BIT = 2;
    localparam int PINEN_BIT = 1;
    localparam int READY_BIT = 0;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_RESERVED = 2'h3;
    localparam int CLK_MHZ = 100;
    localparam int XRST_TIME_US = 100;
    localparam int PULSE_TIME_MS = 50;
    localparam int XRST_CYCLES = XRST_TIME_US * CLK_MHZ;
    localparam int PULSE_CYCLES = PULSE_TIME_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_CYCLES = 16;
    localparam int CNT_W = 23;
endpackage

// ==== pm_timer.sv ====
// Timer: loads on start, counts down, pulses done when it expires
`timescale 1ns/1ns
module pm_timer (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Control
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic [22:0] load_in,
    // Status
    output logic busy_out,
    output logic done_out
);
    logic [22:0] cnt_q;

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            cnt_q <= 23'h00_0000;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else if (abort_in) begin
            cnt_q <= 23'h00_0000;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else if (start_in) begin
            cnt_q <= load_in;
            busy_out <= 1'b1;
            done_out <= 1'b0;
        end else if (busy_out && cnt_q <= 23'h00_0001) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
        end else begin
            if (busy_out) begin
                cnt_q <= cnt_q - 23'h00_0001;
            end
            done_out <= 1'b0;
        end
    end
endmodule

// ==== pm_wake_chk_assertions.sv ====
// Assertion checker for the power management control block
`timescale 1ns/1ns
module pm_wake_chk (
    // Clock, reset and register port
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    // Watched outputs and events
    input wire logic [31:0] rdata_out,
    input wire logic lan_wake_event_in,
    input wire logic energy_event_in,
    input wire logic wake_interrupt_out,
    input wire logic transceiver_reset_out,
    input wire logic [1:0] power_state_select_out,
    input wire logic ready_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    logic [15:0] hold_q;
    logic [2:0] ev_q;
    always_ff @(posedge ref_clk_in) begin
        hold_q <= (rstn_in && transceiver_reset_out) ? hold_q + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge ref_clk_in) begin
        ev_q <= {ev_q[1:0], lan_wake_event_in | energy_event_in};
    end
    sequence wake_write_s;
        wr_in && addr_in == 8'h64 && power_state_select_out != 2'h0;
    endsequence
    sequence ready_up_s;
        !ready_out ##1 ready_out;
    endsequence
    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
        else $error("read data outside read answer cycle");
    xrst_hold_a: assert property ($fell(transceiver_reset_out) |-> hold_q >= 16'(pm_pkg::XRST_CYCLES))
        else $error("transceiver reset released early");
    xrst_cause_a: assert property ($rose(transceiver_reset_out) |-> $past(wr_in && wdata_in[10], 2))
        else $error("transceiver reset without a write");
    mode_legal_a: assert property (power_state_select_out != 2'h3)
        else $error("reserved power state shown");
    sleep_busy_a: assert property (power_state_select_out != 2'h0 |-> !ready_out)
        else $error("ready while asleep");
    wake_write_a: assert property (wake_write_s |-> ##[1:4] power_state_select_out == 2'h0)
        else $error("byte test write did not wake");
    ready_norm_a: assert property (ready_up_s |-> power_state_select_out == 2'h0 && !$past(ready_out, 8))
        else $error("ready rose too soon");
    int_cause_a: assert property ($rose(wake_interrupt_out) |-> ev_q != 3'h0)
        else $error("interrupt without event");
endmodule
bind pm_wake_ctrl pm_wake_chk chk (.ref_clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .lan_wake_event_in, .energy_event_in, .wake_interrupt_out, .transceiver_reset_out, .power_state_select_out,
    .ready_out);

// ==== pm_wake_ctrl.sv ====
// Power management control register with wake indication and self-timed transceiver reset
`timescale 1ns/1ns
// Function
// - Bits 13-12 pick normal, wake-frame detect or energy detect; 11b reserved.
// - A write to byte-order test register wakes a sleeping device, given a read since reset or the last wake.
// - Bit 10 resets transceiver for at least 100us, then self-clears.
// - Writes to bit 10 are ignored while it reads high.
// - Lan wake enable routes wake events to pin and interrupt.
// - Energy detect enable routes energy events to pin and interrupt.
// - Bit 6 clear gives open-drain active-low pin; set gives push-pull.
// - Push-pull polarity: bit 2 set active high, clear active low.
// - Bits 5-4 report wake cause: none, energy, frame, multiple.
// - Write one clears cause bits, only when awake, ready and sources clear.
// - Bit 3 set pulses pin 50ms; clear holds it active.
// - Clearing cause bits or enable deasserts the wake pin.
// - Pin enable gates only the pin, never the interrupt.
// - Ready bit set once the device is stable after power-up or wake.
// - Control register readable in every state; writes to it dropped while not ready.
module pm_wake_ctrl (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // Event sources, level while pending
    input wire logic lan_wake_event_in,
    input wire logic energy_event_in,
    // Wake pin, three signals
    input wire logic wake_event_pin_in,
    output logic wake_event_pin_out,
    output logic wake_event_pin_oe_out,
    // Internal outputs
    output logic wake_interrupt_out,
    output logic transceiver_reset_out,
    output logic [1:0] power_state_select_out,
    output logic ready_out
);
    logic [1:0] mode_q;
    logic lanw_q, endet_q, buft_q, pulse_q, pol_q, pinen_q;
    logic [1:0] cause_q;
    logic ready_q;
    logic read_seen_q;
    logic ind_q;
    logic [4:0] settle_q;
    logic x_busy, p_busy;
    logic wr_ok, wr_ctrl, wake_wr, lan_hit, en_hit, hit, cause_clr_ok;
    logic wake_now, ready_now;
    logic [31:0] ctrl_word;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
        return a == ref_a;
    endfunction

    function automatic logic [1:0] mode_field(input logic [31:0] w);
        return w[pm_pkg::MODE_HI:pm_pkg::MODE_LO];
    endfunction

    // -------------------------------------------------------------
    // Access qualification
    // -------------------------------------------------------------
    // Writes need a prior read; not-ready writes other than wake test are dropped
    assign wr_ok = wr_in && read_seen_q;
    assign wr_ctrl = wr_ok && ready_q && addr_is(addr_in, pm_pkg::ADDR_PM_CTRL);
    assign wake_wr = wr_ok && addr_is(addr_in, pm_pkg::ADDR_BYTE_TEST) && mode_q != pm_pkg::MODE_NORMAL;
    assign cause_clr_ok = ready_q && mode_q == pm_pkg::MODE_NORMAL && !lan_wake_event_in
        && !energy_event_in;

    // -------------------------------------------------------------
    // Event qualification
    // -------------------------------------------------------------
    assign lan_hit = lanw_q && lan_wake_event_in;
    assign en_hit = endet_q && energy_event_in;
    assign hit = lan_hit || en_hit;
    assign wake_now = mode_q != pm_pkg::MODE_NORMAL && (wake_wr || hit);
    // Ready shown only beside the normal state, so both outputs move on one edge when sleep begins
    assign ready_now = ready_q && mode_q == pm_pkg::MODE_NORMAL;

    // -------------------------------------------------------------
    // Read-before-write guard
    // -------------------------------------------------------------
    // Any return from sleep, by event or by test write, needs a fresh read
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            read_seen_q <= 1'b0;
        end else if (wake_now) begin
            read_seen_q <= 1'b0;
        end else if (rd_in) begin
            read_seen_q <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Power state and ready
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            mode_q <= pm_pkg::MODE_NORMAL;
        end else if (wake_now) begin
            mode_q <= pm_pkg::MODE_NORMAL;
        end else if (wr_ctrl && mode_field(wdata_in) != pm_pkg::MODE_RESERVED) begin
            mode_q <= mode_field(wdata_in);
        end
    end

    // Ready drops on sleep, comes back after a settle time
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            ready_q <= 1'b0;
            settle_q <= 5'h00;
        end else if (mode_q != pm_pkg::MODE_NORMAL) begin
            ready_q <= 1'b0;
            settle_q <= 5'h00;
        end else if (!ready_q) begin
            if (settle_q == 5'(pm_pkg::SETTLE_CYCLES - 1)) begin
                ready_q <= 1'b1;
            end else begin
                settle_q <= settle_q + 5'h01;
            end
        end
    end

    // -------------------------------------------------------------
    // Transceiver reset
    // -------------------------------------------------------------
    // Writes of bit 10 while the bit is high are ignored since start needs !x_busy; other fields still load
    pm_timer xrst_timer (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .start_in(wr_ctrl && wdata_in[pm_pkg::XRST_BIT] && !x_busy),
        .abort_in(1'b0),
        .load_in(23'(pm_pkg::XRST_CYCLES)),
        .busy_out(x_busy),
        .done_out()
    );

    // -------------------------------------------------------------
    // Configuration bits
    // -------------------------------------------------------------
    // Event enables
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            lanw_q <= 1'b0;
            endet_q <= 1'b0;
        end else if (wr_ctrl) begin
            lanw_q <= wdata_in[pm_pkg::LANW_BIT];
            endet_q <= wdata_in[pm_pkg::ENDET_BIT];
        end
    end

    // Pin configuration
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            buft_q <= 1'b0;
            pulse_q <= 1'b0;
            pol_q <= 1'b0;
            pinen_q <= 1'b0;
        end else if (wr_ctrl) begin
            buft_q <= wdata_in[pm_pkg::BUFT_BIT];
            pulse_q <= wdata_in[pm_pkg::PULSE_BIT];
            pol_q <= wdata_in[pm_pkg::POL_BIT];
            pinen_q <= wdata_in[pm_pkg::PINEN_BIT];
        end
    end

    // -------------------------------------------------------------
    // Wake cause status
    // -------------------------------------------------------------
    // Set wins over a same-cycle clear
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            cause_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0) ? en_hit : lan_hit) begin
                    cause_q[i] <= 1'b1;
                end else if (wr_ctrl && cause_clr_ok && wdata_in[pm_pkg::CAUSE_LO + i]) begin
                    cause_q[i] <= 1'b0;
                end
            end
        end
    end

    // -------------------------------------------------------------
    // Wake indication
    // -------------------------------------------------------------
    logic lan_active, en_active, ind_kill, new_hit;
    assign lan_active = cause_q[1] && lanw_q;
    assign en_active = cause_q[0] && endet_q;
    assign ind_kill = !lan_active && !en_active && !hit;
    assign new_hit = hit && !ind_q;

    // -------------------------------------------------------------
    // Pulse timer
    // -------------------------------------------------------------
    // Started on the first hit only; a held event does not restart it
    pm_timer pulse_timer (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .start_in(new_hit && pulse_q),
        .abort_in(ind_kill),
        .load_in(23'(pm_pkg::PULSE_CYCLES)),
        .busy_out(p_busy),
        .done_out()
    );

    // Indication level: held in both modes; pulse timing is applied at the pin only
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            ind_q <= 1'b0;
        end else if (ind_kill) begin
            ind_q <= 1'b0;
        end else if (hit) begin
            ind_q <= 1'b1;
        end
    end

    logic pin_active;
    assign pin_active = pinen_q && ind_q && (pulse_q ? p_busy : 1'b1);

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            wake_interrupt_out <= 1'b0;
        end else begin
            wake_interrupt_out <= ind_q;
        end
    end

    // Open drain only pulls low, so the polarity bit has no say there
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            wake_event_pin_out <= 1'b0;
            wake_event_pin_oe_out <= 1'b0;
        end else if (!buft_q) begin
            wake_event_pin_out <= 1'b0;
            wake_event_pin_oe_out <= pin_active;
        end else begin
            wake_event_pin_out <= pol_q ? pin_active : !pin_active;
            wake_event_pin_oe_out <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[pm_pkg::MODE_HI:pm_pkg::MODE_LO] = mode_q;
        ctrl_word[pm_pkg::XRST_BIT] = x_busy;
        ctrl_word[pm_pkg::LANW_BIT] = lanw_q;
        ctrl_word[pm_pkg::ENDET_BIT] = endet_q;
        ctrl_word[pm_pkg::BUFT_BIT] = buft_q;
        ctrl_word[pm_pkg::CAUSE_HI:pm_pkg::CAUSE_LO] = cause_q;
        ctrl_word[pm_pkg::PULSE_BIT] = pulse_q;
        ctrl_word[pm_pkg::POL_BIT] = pol_q;
        ctrl_word[pm_pkg::PINEN_BIT] = pinen_q;
        ctrl_word[pm_pkg::READY_BIT] = ready_now;
    end

    // Control register readable always; others read zero here
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (rd_in && addr_is(addr_in, pm_pkg::ADDR_PM_CTRL)) begin
            rdata_out <= ctrl_word;
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    // -------------------------------------------------------------
    // Status outputs
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            transceiver_reset_out <= 1'b0;
        end else begin
            transceiver_reset_out <= x_busy;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            power_state_select_out <= pm_pkg::MODE_NORMAL;
        end else begin
            power_state_select_out <= mode_q;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            ready_out <= 1'b0;
        end else begin
            ready_out <= ready_now;
        end
    end
endmodule

// ==== test_power_mgmt_wake_control.sv ====
// Self-checking bench for the power management control block
`timescale 1ns/1ns
module test_power_mgmt_wake_control;
    typedef struct { logic [31:0] cfg; logic ev; logic [3:0] pins; } row_t;
    row_t rows [6] = '{'{32'h0000_0202, 1'b0, 4'h4}, '{32'h0000_0106, 1'b1, 4'h4}, '{32'h0000_0246, 1'b0, 4'hd},
        '{32'h0000_0142, 1'b1, 4'h7}, '{32'h0000_0200, 1'b0, 4'h0}, '{32'h0000_024e, 1'b0, 4'hd}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic lan = 1'b0;
    logic nrg = 1'b0;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rv;
    logic wr, rd, pin, oe, intr, xrst, rdy;
    logic [1:0] mode;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    longint t0;
    // Pull-up on the shared wake line
    wire logic lvl = oe ? pin : 1'b1;
    pm_wake_ctrl uut (.ref_clk_in(clk), .rstn_in(rst_n), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .lan_wake_event_in(lan), .energy_event_in(nrg), .wake_event_pin_in(lvl),
        .wake_event_pin_out(pin), .wake_event_pin_oe_out(oe), .wake_interrupt_out(intr),
        .transceiver_reset_out(xrst), .power_state_select_out(mode), .ready_out(rdy));
    host_bus_model host (.ref_clk_in(clk), .ready_in(rdy), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
        .rd_out(rd), .rdata_in(rdata));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        host.wait_ready();
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        do_reset();
        host.read(8'h84, rv);
        check("reset value", 32'h0000_0001, rv);
        for (int i = 0; i < 6; i++) begin
            host.write(8'h84, rows[i].cfg);
            lan <= !rows[i].ev;
            nrg <= rows[i].ev;
            tick(4);
            check("interrupt", 1, intr);
            check("active pin", rows[i].pins[3:2], {pin, oe});
            host.read(8'h84, rv);
            check("cause", rows[i].ev ? 2'h1 : 2'h2, rv[5:4]);
            lan <= 1'b0;
            nrg <= 1'b0;
            host.write(8'h84, rows[i].cfg | 32'h0000_0030);
            tick(3);
            check("idle pin", rows[i].pins[1:0], {pin, oe});
            check("interrupt off", 0, intr);
            $display("row %0d done", i);
        end
        host.write(8'h84, 32'h0000_0400);
        tick(1);
        t0 = $time;
        check("xrst on", 1, xrst);
        tick(5000);
        host.write(8'h84, 32'h0000_0400);
        host.read(8'h84, rv);
        check("xrst bit", 1, rv[10]);
        while (xrst === 1'b1 && cyc < 29000) tick(1);
        n = int'(($time - t0) / 10);
        check("xrst length", 1, n >= pm_pkg::XRST_CYCLES - 2 && n < pm_pkg::XRST_CYCLES + 100);
        host.write(8'h84, 32'h0000_3000);
        tick(1);
        check("reserved mode", 0, mode);
        host.write(8'h84, 32'h0000_1200);
        tick(1);
        check("sleep ready", 0, rdy);
        lan <= 1'b1;
        tick(4);
        check("woken", 0, mode);
        lan <= 1'b0;
        host.wait_ready();
        host.write(8'h84, 32'h0000_0230);
        host.read(8'h84, rv);
        check("cause kept", 2'h2, rv[5:4]);
        host.write(8'h84, 32'h0000_2300);
        tick(1);
        check("energy mode", 2, mode);
        host.write(8'h64, 32'h1234_5678);
        tick(4);
        check("woken by write", 0, mode);
        host.wait_ready();
        host.read(8'h88, rv);
        check("unmapped", 0, rv);
        lan <= 1'b1;
        nrg <= 1'b1;
        tick(4);
        host.write(8'h84, 32'h0000_0330);
        host.read(8'h84, rv);
        check("multi cause", 2'h3, rv[5:4]);
        $display("wake tests done");
        do_reset();
        host.write(8'h84, 32'h0000_0202);
        host.read(8'h84, rv);
        check("write before read", 32'h0000_0001, rv);
        $display("reset test done");
        complete_run();
    end
endmodule
